// ==== test/monitor_model.sv ====
// boost comparator stand-in driven from a boost level
`default_nettype none
module monitor_model
	import reset_gate_pkg::*;
(
	input wire logic [reset_gate_pkg::THR_W-1:0] boost_threshold,
	input wire logic [7:0] boost_level,
	output logic boost_cmp_raw
);
	timeunit 1ns;
	timeprecision 1ps;
	// high while boost sits under the threshold
	assign boost_cmp_raw = boost_level < boost_threshold;
endmodule
`default_nettype wire

// ==== test/reset_predrive_gate_sva.sv ====
// assertion checker for reset_predrive_gate
`default_nettype none
module reset_predrive_gate_sva
	import reset_gate_pkg::*;
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic core_2v5_low_raw,
	input wire logic serial_if_in_reset,
	input wire logic external_reset_pin_n,
	input wire logic logic_core_reset_n,
	input wire logic ext_reset_pin_copy,
	input wire logic five_volt_undervoltage,
	input wire logic predrive_supply_undervoltage,
	input wire logic [reset_gate_pkg::HS_N-1:0] hs_in,
	input wire logic [reset_gate_pkg::LS_N-1:0] ls_in,
	input wire logic [reset_gate_pkg::HS_N-1:0] hs_command,
	input wire logic [reset_gate_pkg::LS_N-1:0] ls_command,
	input wire logic boost_low_flag,
	input wire logic boost_mon_mode,
	input wire logic boost_fbk,
	input wire logic [reset_gate_pkg::RATIO_W-1:0] boost_div_ratio,
	input wire logic over_temp_raw,
	input wire logic over_temp_flag
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	AST_CORE_RST: assert property (logic_core_reset_n ==
		(core_2v5_low_raw && !serial_if_in_reset && external_reset_pin_n)) else $error("core reset");
	AST_PIN_COPY: assert property (ext_reset_pin_copy == external_reset_pin_n)
		else $error("pin copy");
	AST_UV5_OFF: assert property (five_volt_undervoltage
		|=> hs_command == 0 && ls_command == 0) else $error("uv5 gate");
	AST_UVP_OFF: assert property (predrive_supply_undervoltage
		|=> !(|{hs_command, ls_command})) else $error("uvp gate");
	AST_BOOST_FLAG: assert property (boost_low_flag == (boost_mon_mode && boost_fbk))
		else $error("boost flag");
	AST_DIV: assert property (boost_div_ratio ==
		($past(boost_mon_mode) ? DIV_NARROW : DIV_WIDE)) else $error("divider");
	AST_HS_RAW: assert property ((hs_command & ~$past(hs_in)) == 0)
		else $error("hs without raw");
	AST_LS_RAW: assert property ((ls_command & ~$past(ls_in)) == 0)
		else $error("ls without raw");
	AST_OT: assert property (over_temp_flag == $past(over_temp_raw, 2))
		else $error("over temp");
	cover property (boost_low_flag);
	cover property (five_volt_undervoltage);
	cover property (!logic_core_reset_n);
endmodule
bind reset_predrive_gate reset_predrive_gate_sva u_sva (.*);
`default_nettype wire

// ==== test/reset_predrive_gate_tb.sv ====
// self-checking bench for reset_predrive_gate
`default_nettype none
module reset_predrive_gate_tb
	import reset_gate_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	logic core_clk = 1'h0, arst_n = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, bandgap_ok_raw = 1'h0;
	logic core_2v5_low_raw = 1'h0, serial_if_in_reset = 1'h0, external_reset_pin_n = 1'h1;
	logic main_5v_low_raw = 1'h0, predrive_low_raw = 1'h0, over_temp_raw = 1'h0;
	logic drive_enable_pin = 1'h0, gate;
	logic [ADDR_W-1:0] reg_addr = 9'h000;
	logic [DATA_W-1:0] reg_wdata = 16'h0000, reg_rdata;
	logic [HS_N-1:0] hs_in = 5'h00, hs_command;
	logic [LS_N-1:0] ls_in = 6'h00, ls_command;
	logic [THR_W-1:0] boost_threshold, boost_level = 8'h00;
	logic [RATIO_W-1:0] boost_div_ratio;
	logic reference_in_range, core_supply_reset_n, serial_if_reset_n, ext_reset_pin_copy;
	logic logic_core_reset_n, five_volt_undervoltage, predrive_supply_undervoltage, irq;
	logic regulator_disable, boost_fbk, boost_mon_mode, boost_low_flag, over_temp_flag;
	logic boost_cmp_raw;
	logic gate_m, hs_off_m;
	logic [15:0] exp_m;
	int hist[$];
	int cfg_m = 0, cur_s;
	int n_fail = 0, samples_checked = 0, g;
	reset_predrive_gate u_dut (.*);
	monitor_model u_mon (.*);
	initial forever #4 core_clk = ~core_clk;
	task automatic chk(string nm, logic [15:0] e, logic [15:0] s);
		samples_checked++;
		if (s !== e) begin
			n_fail++;
			$display("BAD %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic wr(logic [8:0] a, logic [15:0] d);
		@(posedge core_clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge core_clk);
		reg_wr <= 1'h0;
	endtask
	// strobe drops on the taking edge; data is sampled once it has landed
	task automatic rd(logic [8:0] a, logic [15:0] e, string nm);
		@(posedge core_clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'h0;
		#1 chk(nm, e, reg_rdata);
	endtask
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// model: monitor levels reach the gates after three edges, commands and config after one
	always @(posedge core_clk) begin
		if (!arst_n) begin
			hist.delete();
			cfg_m = 0;
		end else begin
			if (hist.size() == 3) begin
				gate_m = !hist[0][11] && !hist[0][12] && hist[0][13];
				hs_off_m = hist[2][15] && hist[2][16] && hist[0][14];
				exp_m = {5'h00, hist[2][4:0] & {5{gate_m && !hs_off_m}}, hist[2][10:5] & {6{gate_m}}};
				chk("cmd model", exp_m, {5'h00, hs_command, ls_command});
			end
			cur_s = {15'h0000, cfg_m[CFG_AUTO_OFF_BIT], cfg_m[CFG_MON_BIT], boost_cmp_raw,
				drive_enable_pin, predrive_low_raw, main_5v_low_raw, ls_in, hs_in};
			if (reg_wr && reg_addr == CFG_ADDR) cfg_m = int'(reg_wdata);
			hist.push_back(cur_s);
			if (hist.size() > 3) void'(hist.pop_front());
		end
	end
	initial begin
		#100000;
		n_fail++;
		report_and_stop();
	end
	initial begin
		void'($urandom(32'h8D4F));
		repeat (6) @(posedge core_clk);
		arst_n <= 1'h1;
		chk("div", 16'(DIV_WIDE), 16'(boost_div_ratio));
		rd(CFG_ADDR, 16'h0000, "cfg");
		rd(THR_ADDR, 16'h0000, "thr");
		rd(MASK_ADDR, 16'h0000, "mask");
		rd(9'h1F0, 16'h0000, "unmapped");
		$display("reset values done");
		for (g = 0; g < 8; g++) begin
			@(posedge core_clk);
			{core_2v5_low_raw, serial_if_in_reset, external_reset_pin_n} <= 3'(g);
			#1 chk("rst", {12'h000, g[2], !g[1], g[0], g[2] & !g[1] & g[0]},
				{12'h000, core_supply_reset_n, serial_if_reset_n, ext_reset_pin_copy, logic_core_reset_n});
		end
		$display("reset chain done");
		for (g = 0; g < 40; g++) begin
			@(posedge core_clk);
			{main_5v_low_raw, predrive_low_raw, drive_enable_pin} <= 3'($urandom_range(7));
			hs_in <= 5'($urandom);
			ls_in <= 6'($urandom);
			repeat (4) @(posedge core_clk);
			#1 gate = !main_5v_low_raw && !predrive_low_raw && drive_enable_pin;
			chk("hs", 16'(hs_in & {HS_N{gate}}), 16'(hs_command));
			chk("ls", 16'(ls_in & {LS_N{gate}}), 16'(ls_command));
			chk("flags", {13'h0000, main_5v_low_raw, predrive_low_raw,
				over_temp_raw}, {13'h0000, five_volt_undervoltage,
				predrive_supply_undervoltage, over_temp_flag});
			rd(STAT_ADDR, {10'h000, drive_enable_pin, 1'h0, predrive_low_raw, main_5v_low_raw, 2'h0},
				"stat");
		end
		$display("gating done");
		@(posedge core_clk);
		{main_5v_low_raw, predrive_low_raw, drive_enable_pin} <= 3'h1;
		wr(EVT_ADDR, 16'h001F);
		wr(MASK_ADDR, 16'h0004);
		rd(EVT_ADDR, 16'h0000, "evt clear");
		chk("irq idle", 16'h0000, 16'(irq));
		@(posedge core_clk);
		main_5v_low_raw <= 1'h1;
		repeat (4) @(posedge core_clk);
		#1 chk("irq", 16'h0001, 16'(irq));
		rd(EVT_ADDR, 16'h0004, "evt");
		@(posedge core_clk);
		main_5v_low_raw <= 1'h0;
		wr(EVT_ADDR, 16'h0004);
		#1 chk("irq off", 16'h0000, 16'(irq));
		$display("interrupt done");
		g = $urandom_range(255, 2);
		wr(THR_ADDR, 16'(g));
		wr(CFG_ADDR, 16'h0007);
		wr(STAT_ADDR, 16'hFFFF);
		@(posedge core_clk);
		boost_level <= 8'(g - 1);
		{over_temp_raw, bandgap_ok_raw} <= 2'h3;
		hs_in <= 5'h1F;
		ls_in <= 6'h3F;
		repeat (4) @(posedge core_clk);
		#1 chk("thr", 16'(g), 16'(boost_threshold));
		chk("mon", 16'h003E, {10'h000, boost_mon_mode,
			reference_in_range, boost_fbk, boost_low_flag, regulator_disable, 1'h0});
		chk("hs off", 16'h0000, 16'(hs_command));
		chk("ls on", 16'h003F, 16'(ls_command));
		chk("div", 16'(DIV_NARROW), 16'(boost_div_ratio));
		rd(STAT_ADDR, 16'h0073, "stat boost");
		wr(CFG_ADDR, 16'h0002);
		repeat (3) @(posedge core_clk);
		#1 chk("mode off", 16'h001F, {8'h00, boost_mon_mode,
			boost_low_flag, regulator_disable, hs_command});
		chk("div", 16'(DIV_WIDE), 16'(boost_div_ratio));
		rd(STAT_ADDR, 16'h0032, "stat plain");
		$display("boost done");
		report_and_stop();
	end
endmodule
`default_nettype wire

// ==== verilog/level_sync.sv ====
// two-flop synchroniser for a group of unrelated levels
`default_nettype none
module level_sync #(
	parameter int WIDTH = 1
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	if (WIDTH < 1) begin : g_bad_width
		$error("level_sync needs WIDTH of at least one");
	end

	// each lane is independent; no multi-bit coherence implied
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule
`default_nettype wire

// ==== verilog/reset_gate_pkg.sv ====
// constants shared by the reset combiner and pre-driver gating
`default_nettype none
package reset_gate_pkg;
	localparam int ADDR_W = 9;
	localparam int DATA_W = 16;
	localparam int HS_N = 5;
	localparam int LS_N = 6;
	localparam int THR_W = 8;
	localparam int RATIO_W = 6;
	localparam int EV_W = 5;
	localparam int SYNC_W = 6;

	// register addresses
	localparam logic [ADDR_W-1:0] CFG_ADDR = 9'h1C5;
	localparam logic [ADDR_W-1:0] THR_ADDR = 9'h1C6;
	localparam logic [ADDR_W-1:0] STAT_ADDR = 9'h1D2;
	localparam logic [ADDR_W-1:0] EVT_ADDR = 9'h1E0;
	localparam logic [ADDR_W-1:0] MASK_ADDR = 9'h1E1;

	// config fields
	localparam int CFG_MON_BIT = 0;
	localparam int CFG_AUTO_OFF_BIT = 1;
	localparam int CFG_EXT_SUP_BIT = 2;
	localparam int CFG_USED_W = 3;

	// status fields
	localparam int ST_BOOST_LOW_BIT = 0;
	localparam int ST_OVER_TEMP_BIT = 1;
	localparam int ST_UV5_BIT = 2;
	localparam int ST_UVP_BIT = 3;
	localparam int ST_REF_BIT = 4;
	localparam int ST_DRVEN_BIT = 5;
	localparam int ST_HS_OFF_BIT = 6;

	// event fields, shared by sticky and mask registers
	localparam int EV_BOOST_BIT = 0;
	localparam int EV_TEMP_BIT = 1;
	localparam int EV_UV5_BIT = 2;
	localparam int EV_UVP_BIT = 3;
	localparam int EV_REF_BIT = 4;

	// synchroniser lanes
	localparam int SY_REF = 0;
	localparam int SY_UV5 = 1;
	localparam int SY_UVP = 2;
	localparam int SY_BOOST = 3;
	localparam int SY_TEMP = 4;
	localparam int SY_DRVEN = 5;

	// reset values
	localparam logic [CFG_USED_W-1:0] CFG_RESET = 3'h0;
	localparam logic [THR_W-1:0] THR_RESET = 8'h00;
	localparam logic [EV_W-1:0] EVT_RESET = 5'h00;
	localparam logic [EV_W-1:0] MASK_RESET = 5'h00;
	// reference lane starts as lost, since its synchroniser resets low
	localparam logic [EV_W-1:0] EV_PREV_RESET = 5'h10;

	// boost divider ratios, as denominators
	localparam logic [RATIO_W-1:0] DIV_WIDE = 6'h04;
	localparam logic [RATIO_W-1:0] DIV_NARROW = 6'h20;
endpackage
`default_nettype wire

// ==== verilog/reset_predrive_gate.sv ====
// reset combiner, supply monitoring and pre-driver command gating
//
// Local design decision: strobed register access.
`default_nettype none
module reset_predrive_gate
	import reset_gate_pkg::*;
#(
	parameter int HS_CNT = reset_gate_pkg::HS_N,
	parameter int LS_CNT = reset_gate_pkg::LS_N
) (
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic [reset_gate_pkg::ADDR_W-1:0] reg_addr,
	input wire logic [reset_gate_pkg::DATA_W-1:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [reset_gate_pkg::DATA_W-1:0] reg_rdata,
	input wire logic bandgap_ok_raw,
	input wire logic core_2v5_low_raw,
	input wire logic serial_if_in_reset,
	input wire logic external_reset_pin_n,
	input wire logic main_5v_low_raw,
	input wire logic predrive_low_raw,
	input wire logic boost_cmp_raw,
	input wire logic over_temp_raw,
	input wire logic drive_enable_pin,
	input wire logic [HS_CNT-1:0] hs_in,
	input wire logic [LS_CNT-1:0] ls_in,
	output logic reference_in_range,
	output logic core_supply_reset_n,
	output logic serial_if_reset_n,
	output logic ext_reset_pin_copy,
	output logic logic_core_reset_n,
	output logic five_volt_undervoltage,
	output logic predrive_supply_undervoltage,
	output logic regulator_disable,
	output logic boost_fbk,
	output logic [reset_gate_pkg::THR_W-1:0] boost_threshold,
	output logic [reset_gate_pkg::RATIO_W-1:0] boost_div_ratio,
	output logic boost_mon_mode,
	output logic boost_low_flag,
	output logic over_temp_flag,
	output logic [HS_CNT-1:0] hs_command,
	output logic [LS_CNT-1:0] ls_command,
	output logic irq
);
	import reset_gate_pkg::*;

	logic [SYNC_W-1:0] raw_vec;
	logic [SYNC_W-1:0] sync_vec;
	logic [CFG_USED_W-1:0] cfg_q;
	logic [THR_W-1:0] thr_q;
	logic [EV_W-1:0] evt_q;
	logic [EV_W-1:0] evt_d;
	logic [EV_W-1:0] mask_q;
	logic [EV_W-1:0] ev_level;
	logic [EV_W-1:0] ev_prev_q;
	logic [EV_W-1:0] ev_rise;
	logic [DATA_W-1:0] rdata_d;
	logic [DATA_W-1:0] status_word;
	logic ref_ok;
	logic uv5;
	logic uvp;
	logic boost_cmp;
	logic temp_hot;
	logic drven;
	logic mon_mode;
	logic boost_low;
	logic hs_auto_off;
	logic supplies_ok;
	logic wr_cfg;
	logic wr_thr;
	logic wr_evt;
	logic wr_mask;

	// counts and field packing the logic can serve
	if (HS_CNT < 1 || LS_CNT < 1) begin : g_bad_count
		$error("each driver side needs at least one channel");
	end
	if (ST_HS_OFF_BIT >= DATA_W || EV_W > DATA_W || THR_W > DATA_W) begin : g_bad_fields
		$error("register fields do not fit the data word");
	end
	if (SY_DRVEN >= SYNC_W || EV_REF_BIT >= EV_W) begin : g_bad_lanes
		$error("lane index beyond its vector");
	end

	// every analog monitor and the enable pin come from outside this clock
	assign raw_vec[SY_REF] = bandgap_ok_raw;
	assign raw_vec[SY_UV5] = main_5v_low_raw;
	assign raw_vec[SY_UVP] = predrive_low_raw;
	assign raw_vec[SY_BOOST] = boost_cmp_raw;
	assign raw_vec[SY_TEMP] = over_temp_raw;
	assign raw_vec[SY_DRVEN] = drive_enable_pin;

	level_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.core_clk(core_clk),
		.arst_n(arst_n),
		.async_in(raw_vec),
		.sync_out(sync_vec)
	);

	assign ref_ok = sync_vec[SY_REF];
	assign uv5 = sync_vec[SY_UV5];
	assign uvp = sync_vec[SY_UVP];
	assign boost_cmp = sync_vec[SY_BOOST];
	assign temp_hot = sync_vec[SY_TEMP];
	assign drven = sync_vec[SY_DRVEN];

	// reset chain stays combinational so it acts without a running clock
	assign core_supply_reset_n = core_2v5_low_raw;
	assign serial_if_reset_n = ~serial_if_in_reset;
	assign ext_reset_pin_copy = external_reset_pin_n;
	assign logic_core_reset_n = core_supply_reset_n & serial_if_reset_n
		& ext_reset_pin_copy;

	// monitor flags, straight from the second synchroniser stage
	assign reference_in_range = ref_ok;
	assign five_volt_undervoltage = uv5;
	assign predrive_supply_undervoltage = uvp;
	assign boost_fbk = boost_cmp;
	assign over_temp_flag = temp_hot;

	// configuration fields
	assign mon_mode = cfg_q[CFG_MON_BIT];
	assign boost_mon_mode = mon_mode;
	assign boost_threshold = thr_q;
	assign boost_low = mon_mode & boost_cmp;
	assign boost_low_flag = boost_low;
	assign hs_auto_off = cfg_q[CFG_AUTO_OFF_BIT] & boost_low;
	assign supplies_ok = ~uv5 & ~uvp;

	// register decode
	assign wr_cfg = reg_wr && (reg_addr == CFG_ADDR);
	assign wr_thr = reg_wr && (reg_addr == THR_ADDR);
	assign wr_evt = reg_wr && (reg_addr == EVT_ADDR);
	assign wr_mask = reg_wr && (reg_addr == MASK_ADDR);

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			cfg_q <= CFG_RESET;
		end else if (wr_cfg) begin
			cfg_q <= reg_wdata[CFG_USED_W-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			thr_q <= THR_RESET;
		end else if (wr_thr) begin
			thr_q <= reg_wdata[THR_W-1:0];
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			mask_q <= MASK_RESET;
		end else if (wr_mask) begin
			mask_q <= reg_wdata[EV_W-1:0];
		end
	end

	// regulator off and divider choice follow config by one flop
	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			regulator_disable <= 1'b0;
			boost_div_ratio <= DIV_WIDE;
		end else begin
			regulator_disable <= cfg_q[CFG_EXT_SUP_BIT];
			boost_div_ratio <= mon_mode ? DIV_NARROW : DIV_WIDE;
		end
	end

	// events are rising edges of fault conditions
	assign ev_level[EV_BOOST_BIT] = boost_low;
	assign ev_level[EV_TEMP_BIT] = temp_hot;
	assign ev_level[EV_UV5_BIT] = uv5;
	assign ev_level[EV_UVP_BIT] = uvp;
	assign ev_level[EV_REF_BIT] = ~ref_ok;

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			// no false reference-lost edge after reset; a reference bad from
			// power-up shows in status only
			ev_prev_q <= EV_PREV_RESET;
		end else begin
			ev_prev_q <= ev_level;
		end
	end

	assign ev_rise = ev_level & ~ev_prev_q;

	// write one clears; a new edge in the same cycle wins
	always_comb begin
		evt_d = evt_q;
		if (wr_evt) begin
			evt_d = evt_d & ~reg_wdata[EV_W-1:0];
		end
		evt_d = evt_d | ev_rise;
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			evt_q <= EVT_RESET;
		end else begin
			evt_q <= evt_d;
		end
	end

	assign irq = |(evt_q & mask_q);

	// live status word
	always_comb begin
		status_word = '0;
		status_word[ST_BOOST_LOW_BIT] = boost_low;
		status_word[ST_OVER_TEMP_BIT] = temp_hot;
		status_word[ST_UV5_BIT] = uv5;
		status_word[ST_UVP_BIT] = uvp;
		status_word[ST_REF_BIT] = ref_ok;
		status_word[ST_DRVEN_BIT] = drven;
		status_word[ST_HS_OFF_BIT] = hs_auto_off;
	end

	// read data in the cycle after the strobe, zero elsewhere and unmapped
	always_comb begin
		rdata_d = '0;
		if (reg_rd) begin
			case (reg_addr)
				CFG_ADDR: rdata_d[CFG_USED_W-1:0] = cfg_q;
				THR_ADDR: rdata_d[THR_W-1:0] = thr_q;
				STAT_ADDR: rdata_d = status_word;
				EVT_ADDR: rdata_d[EV_W-1:0] = evt_q;
				MASK_ADDR: rdata_d[EV_W-1:0] = mask_q;
				default: rdata_d = '0;
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge arst_n) begin
		if (!arst_n) begin
			reg_rdata <= '0;
		end else begin
			reg_rdata <= rdata_d;
		end
	end

	// gate commands; registered, so a fault removes drive one cycle later
	for (genvar i = 0; i < HS_CNT; i++) begin : g_hs
		always_ff @(posedge core_clk or negedge arst_n) begin
			if (!arst_n) begin
				hs_command[i] <= 1'b0;
			end else begin
				hs_command[i] <= hs_in[i] & supplies_ok & drven & ~hs_auto_off;
			end
		end
	end

	for (genvar j = 0; j < LS_CNT; j++) begin : g_ls
		always_ff @(posedge core_clk or negedge arst_n) begin
			if (!arst_n) begin
				ls_command[j] <= 1'b0;
			end else begin
				ls_command[j] <= ls_in[j] & supplies_ok & drven;
			end
		end
	end
endmodule
`default_nettype wire
